// ==== gyro_alarm_pkg.sv ====
package gyro_alarm_pkg;
    localparam int SYS_CLK_HZ = 250_000_000;
    localparam int SLOPE_FS_MAX_HZ = 400;
    localparam int SLOPE_TICK_CYCLES = SYS_CLK_HZ / (4 * SLOPE_FS_MAX_HZ);
    localparam int HIGH_STEP_US = 2500;
    localparam int HIGH_STEP_CYCLES = SYS_CLK_HZ / 1_000_000 * HIGH_STEP_US;
    // bandwidth codes at or below this one run at the capped update rate
    localparam logic [2:0] BW_FS_CAP_CODE = 3'h2;

    localparam logic [7:0] IDX_STATUS = 8'h09;
    localparam logic [7:0] IDX_SLOPE_INFO = 8'h0B;
    localparam logic [7:0] IDX_FAST_INFO = 8'h0C;
    localparam logic [7:0] IDX_RO_LAST = 8'h0E;
    localparam logic [7:0] IDX_SLOPE_TH = 8'h1B;
    localparam logic [7:0] IDX_SLOPE_CFG = 8'h1C;
    localparam logic [7:0] IDX_INT_MODE = 8'h21;
    localparam logic [2:0][7:0] IDX_FAST_CFG = {8'h26, 8'h24, 8'h22};
    localparam logic [2:0][7:0] IDX_FAST_DUR = {8'h27, 8'h25, 8'h23};

    localparam int ST_SLOPE_BIT = 2;
    localparam int ST_FAST_BIT = 1;
    localparam int INFO_SIGN_BIT = 3;
    localparam int CFG_DUR_LSB = 4;
    localparam int FT_EN_BIT = 0;
    localparam int FT_TH_LSB = 1;
    localparam int FT_HY_LSB = 6;
    localparam int RESET_INT_BIT = 7;

    localparam logic [3:0] MODE_LATCHED_LO = 4'h7;
    localparam logic [3:0] MODE_LATCHED_HI = 4'hF;

    localparam logic [7:0] RST_SLOPE_TH = 8'h00;
    localparam logic [4:0] RST_SLOPE_CFG = 5'h00;
    localparam logic [3:0] RST_INT_MODE = 4'h0;
    localparam logic [7:0] RST_FAST_CFG = 8'h00;
    localparam logic [7:0] RST_FAST_DUR = 8'h00;

    // raw counts: 16-bit sample spans the full range, so steps are range independent
    localparam logic [16:0] FAST_ZERO_RAW = 17'h003FC;
    localparam logic [18:0] SLOPE_SCALE_NUM = 19'h00800;
    localparam logic [18:0] SLOPE_SCALE_DEN = 19'h0007D;
    localparam logic [4:0] SLOPE_CNT_MAX = 5'h10;

    typedef struct packed {
        logic [2:0][15:0] axis;
    } rate_sample_t;
endpackage

// ==== gyro_slope_and_rate_alarm.sv ====
// The APB register port is this design's own decision.
`timescale 1ns/10ps
// Functional notes
// (RULE1) slope is absolute difference of successive samples
// (RULE2) slope threshold step 1 dps at 2000 range
// (RULE3) slope points at quarter update period, 400 Hz cap
// (RULE4) N consecutive points to set or clear, N=4..16
// (RULE5) per-axis slope enables, any enabled axis sets
// (RULE6) clear needs all enabled axes below; not latched
// (RULE7) slope state readable in status register
// (RULE8) one-hot slope trigger axis flags
// (RULE9) slope sign held until retrigger, one positive
// (RULE10) per-axis fast turn enables in three registers
// (RULE11) per-axis fast turn threshold, 62.5 dps step
// (RULE12) per-axis hysteresis, zero means 62.26 dps
// (RULE13) fast turn sets after threshold held for duration
// (RULE14) fast turn resets when all below threshold minus hysteresis
// (RULE15) duration is field plus one times 2.5 ms
// (RULE16) fast turn state in same status register
// (RULE17) one-hot fast turn axis, cleared with status
// (RULE18) fast turn sign stored, one positive
// (RULE19) common mode field; latched clears by reset write
// (RULE20) status updates on new data; disable clears
// (RULE21) comparisons in raw units for selected range
module gyro_slope_and_rate_alarm
    import gyro_alarm_pkg::*;
#(
    parameter int SLOPE_TICK = SLOPE_TICK_CYCLES,
    parameter int HIGH_STEP = HIGH_STEP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rate_valid,
    input wire rate_sample_t rate_in,
    input wire logic [2:0] range_sel,
    input wire logic [2:0] bw_sel,
    output logic slope_event,
    output logic fast_turn_event
);
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [7:0] slope_th_q, slope_th_d;
    logic [4:0] slope_cfg_q, slope_cfg_d;
    logic [3:0] mode_q, mode_d;
    logic [2:0][7:0] fast_cfg_q, fast_cfg_d, fast_dur_q, fast_dur_d;

    logic [2:0] range_q, range_d;
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic pend_q, pend_d, prev_ok_q, prev_ok_d;
    rate_sample_t prev_q, prev_d;
    logic [2:0][4:0] sl_up_q, sl_up_d, sl_dn_q, sl_dn_d;
    logic slope_q, slope_d, slope_sign_q, slope_sign_d;
    logic [2:0] slope_axis_q, slope_axis_d;
    logic [2:0] ft_above_q, ft_above_d;
    logic [2:0][31:0] ft_cnt_q, ft_cnt_d;
    logic fast_q, fast_d, fast_sign_q, fast_sign_d;
    logic [2:0] fast_axis_q, fast_axis_d;

    logic access, rd_sel, wr_fire, idx_ok, clr_wr, latched, point;
    logic [7:0] idx, rd_byte;
    logic [1:0] slope_dur;
    logic [2:0] slope_en, fast_en, sl_hi, sl_dir, ft_hi, ft_lo, ft_qual;
    logic [4:0] n_samp;
    logic [16:0] slope_thr;
    logic [2:0] shift;
    logic [31:0] tick_lim;

    assign access = psel && penable;
    assign idx = paddr[9:2];
    assign wr_fire = access && pready_q && pwrite && !pslverr_q;
    assign slope_dur = slope_cfg_q[4:3];
    assign slope_en = slope_cfg_q[2:0];
    assign n_samp = 5'(({3'h0, slope_dur} + 5'h01) << 2); // RULE4
    assign slope_thr = 17'((slope_th_q * SLOPE_SCALE_NUM) / SLOPE_SCALE_DEN); // RULE2 RULE21
    assign latched = (mode_q == MODE_LATCHED_LO) || (mode_q == MODE_LATCHED_HI); // RULE19
    assign clr_wr = wr_fire && (idx == IDX_INT_MODE) && pwdata[RESET_INT_BIT]; // RULE19
    // at or below the cap every bandwidth code shares the 1600 Hz point spacing
    assign shift = (bw_sel <= BW_FS_CAP_CODE) ? 3'h0 : 3'(bw_sel - BW_FS_CAP_CODE);
    assign tick_lim = 32'((SLOPE_TICK << shift) - 1); // RULE3
    assign point = rate_valid && pend_q; // RULE20

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            logic signed [16:0] diff;
            logic [16:0] dmag, mag, thr, hy;
            logic signed [17:0] low;
            assign diff = 17'($signed(rate_in.axis[g])) - 17'($signed(prev_q.axis[g]));
            assign dmag = diff[16] ? 17'(-diff) : diff; // RULE1
            assign sl_hi[g] = dmag > slope_thr; // RULE1
            assign sl_dir[g] = !diff[16]; // RULE9
            assign mag = rate_in.axis[g][15] ? 17'(-$signed({rate_in.axis[g][15],
                rate_in.axis[g]})) : {1'b0, rate_in.axis[g]};
            assign thr = {2'h0, fast_cfg_q[g][FT_TH_LSB +: 5], 10'h000} + FAST_ZERO_RAW; // RULE11
            assign hy = {5'h00, fast_cfg_q[g][FT_HY_LSB +: 2], 10'h000} + FAST_ZERO_RAW; // RULE12
            assign low = $signed({1'b0, thr}) - $signed({1'b0, hy});
            assign ft_hi[g] = mag > thr; // RULE13
            assign ft_lo[g] = $signed({1'b0, mag}) < low; // RULE14
            assign fast_en[g] = fast_cfg_q[g][FT_EN_BIT]; // RULE10
            assign ft_qual[g] = fast_en[g] && ft_hi[g] && ft_above_q[g] &&
                (ft_cnt_q[g] >= 32'((fast_dur_q[g] + 32'h1) * HIGH_STEP)); // RULE13 RULE15
        end
    endgenerate

    always_comb begin
        idx_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
            ((idx == IDX_STATUS) || (idx == IDX_SLOPE_INFO) || (idx == IDX_FAST_INFO) ||
            (idx == IDX_SLOPE_TH) || (idx == IDX_SLOPE_CFG) || (idx == IDX_INT_MODE) ||
            (idx == IDX_FAST_CFG[0]) || (idx == IDX_FAST_CFG[1]) || (idx == IDX_FAST_CFG[2]) ||
            (idx == IDX_FAST_DUR[0]) || (idx == IDX_FAST_DUR[1]) || (idx == IDX_FAST_DUR[2]));
        rd_byte = 8'h00;
        case (idx)
            IDX_STATUS: begin
                rd_byte[ST_SLOPE_BIT] = slope_q; // RULE7
                rd_byte[ST_FAST_BIT] = fast_q; // RULE16
            end
            IDX_SLOPE_INFO: rd_byte = {4'h0, slope_sign_q, slope_axis_q}; // RULE8 RULE9
            IDX_FAST_INFO: rd_byte = {4'h0, fast_sign_q, fast_axis_q}; // RULE17 RULE18
            IDX_SLOPE_TH: rd_byte = slope_th_q;
            IDX_SLOPE_CFG: rd_byte = {2'h0, slope_dur, 1'b0, slope_en};
            IDX_INT_MODE: rd_byte = {4'h0, mode_q};
            IDX_FAST_CFG[0]: rd_byte = fast_cfg_q[0];
            IDX_FAST_CFG[1]: rd_byte = fast_cfg_q[1];
            IDX_FAST_CFG[2]: rd_byte = fast_cfg_q[2];
            IDX_FAST_DUR[0]: rd_byte = fast_dur_q[0];
            IDX_FAST_DUR[1]: rd_byte = fast_dur_q[1];
            IDX_FAST_DUR[2]: rd_byte = fast_dur_q[2];
            default: rd_byte = 8'h00;
        endcase
        rd_sel = access && !pready_q;
        pready_d = rd_sel;
        pslverr_d = rd_sel && (!idx_ok || (pwrite && (idx <= IDX_RO_LAST)));
        prdata_d = (rd_sel && !pwrite && idx_ok) ? {24'h000000, rd_byte} : 32'h00000000;
        slope_th_d = slope_th_q;
        slope_cfg_d = slope_cfg_q;
        mode_d = mode_q;
        fast_cfg_d = fast_cfg_q;
        fast_dur_d = fast_dur_q;
        if (wr_fire) begin
            if (idx == IDX_SLOPE_TH) begin
                slope_th_d = pwdata[7:0];
            end
            if (idx == IDX_SLOPE_CFG) begin
                slope_cfg_d = {pwdata[CFG_DUR_LSB +: 2], pwdata[2:0]}; // RULE4 RULE5
            end
            if (idx == IDX_INT_MODE) begin
                mode_d = pwdata[3:0]; // RULE19
            end
            for (int i = 0; i < 3; i++) begin
                if (idx == IDX_FAST_CFG[i]) begin
                    fast_cfg_d[i] = pwdata[7:0]; // RULE10
                end
                if (idx == IDX_FAST_DUR[i]) begin
                    fast_dur_d[i] = pwdata[7:0]; // RULE15
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            slope_th_q <= RST_SLOPE_TH;
            slope_cfg_q <= RST_SLOPE_CFG;
            mode_q <= RST_INT_MODE;
            fast_cfg_q <= {3{RST_FAST_CFG}};
            fast_dur_q <= {3{RST_FAST_DUR}};
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            slope_th_q <= slope_th_d;
            slope_cfg_q <= slope_cfg_d;
            mode_q <= mode_d;
            fast_cfg_q <= fast_cfg_d;
            fast_dur_q <= fast_dur_d;
        end
    end

    always_comb begin
        logic set_any, clr_all, range_chg, fset, fclr;
        logic [2:0] hit, fhit;
        set_any = 1'b0;
        clr_all = 1'b1;
        fset = 1'b0;
        fclr = 1'b1;
        hit = 3'h0;
        fhit = 3'h0;
        range_chg = range_sel != range_q;
        range_d = range_sel;
        // a range switch rescales every sample, so old history is dropped
        tick_cnt_d = (tick_cnt_q >= tick_lim) ? 32'h0 : tick_cnt_q + 32'h1; // RULE3
        pend_d = (pend_q && !point) || (tick_cnt_q >= tick_lim); // RULE3
        prev_d = point ? rate_in : prev_q;
        prev_ok_d = prev_ok_q || point;
        sl_up_d = sl_up_q;
        sl_dn_d = sl_dn_q;
        ft_above_d = ft_above_q;
        ft_cnt_d = ft_cnt_q;
        slope_d = slope_q;
        slope_axis_d = slope_axis_q;
        slope_sign_d = slope_sign_q;
        fast_d = fast_q;
        fast_axis_d = fast_axis_q;
        fast_sign_d = fast_sign_q;
        for (int i = 0; i < 3; i++) begin
            if (!slope_en[i] || range_chg) begin
                sl_up_d[i] = 5'h00;
                sl_dn_d[i] = 5'h00;
            end else if (point && prev_ok_q) begin
                sl_up_d[i] = sl_hi[i] ? ((sl_up_q[i] < SLOPE_CNT_MAX) ? sl_up_q[i] + 5'h01 :
                    SLOPE_CNT_MAX) : 5'h00; // RULE4
                sl_dn_d[i] = sl_hi[i] ? 5'h00 : ((sl_dn_q[i] < SLOPE_CNT_MAX) ?
                    sl_dn_q[i] + 5'h01 : SLOPE_CNT_MAX); // RULE4
            end
            if (slope_en[i] && (sl_up_d[i] >= n_samp) && !hit[0] && !hit[1]) begin
                hit[i] = 1'b1; // RULE5 RULE8
            end
            if (slope_en[i] && (sl_dn_d[i] < n_samp)) begin
                clr_all = 1'b0; // RULE6
            end
            ft_cnt_d[i] = (ft_above_q[i] && !range_chg) ? ((ft_cnt_q[i] == 32'hFFFFFFFF) ?
                ft_cnt_q[i] : ft_cnt_q[i] + 32'h1) : 32'h0; // RULE15
            if (rate_valid) begin
                ft_above_d[i] = fast_en[i] && ft_hi[i]; // RULE13
                if (ft_qual[i] && !fset) begin
                    fset = 1'b1;
                    fhit[i] = 1'b1; // RULE13 RULE17
                end
                if (fast_en[i] && !ft_lo[i]) begin
                    fclr = 1'b0; // RULE14
                end
            end
        end
        set_any = point && prev_ok_q && (hit != 3'h0);
        // clears first so that a fresh trigger in the same cycle wins
        if ((latched && clr_wr) || (!latched && point && prev_ok_q && clr_all)) begin
            slope_d = 1'b0; // RULE6 RULE19
        end
        if (set_any && !(slope_q && !clr_wr)) begin
            slope_d = 1'b1; // RULE5 RULE20
            slope_axis_d = hit; // RULE8
            slope_sign_d = |(hit & sl_dir); // RULE9
        end
        if ((latched && clr_wr) || (!latched && rate_valid && fclr)) begin
            fast_d = 1'b0; // RULE14 RULE19
            fast_axis_d = 3'h0; // RULE17
        end
        if (rate_valid && fset && !(fast_q && !clr_wr)) begin
            fast_d = 1'b1; // RULE13 RULE20
            fast_axis_d = fhit; // RULE17
            fast_sign_d = |(fhit & ~{rate_in.axis[2][15], rate_in.axis[1][15],
                rate_in.axis[0][15]}); // RULE18
        end
        if (slope_en == 3'h0) begin
            slope_d = 1'b0; // RULE20
        end
        if (fast_en == 3'h0) begin
            fast_d = 1'b0; // RULE20
            fast_axis_d = 3'h0; // RULE17
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            range_q <= 3'h0;
            tick_cnt_q <= 32'h0;
            pend_q <= 1'b0;
            prev_ok_q <= 1'b0;
            prev_q <= '0;
            sl_up_q <= '0;
            sl_dn_q <= '0;
            ft_above_q <= 3'h0;
            ft_cnt_q <= '0;
            slope_q <= 1'b0;
            slope_axis_q <= 3'h0;
            slope_sign_q <= 1'b0;
            fast_q <= 1'b0;
            fast_axis_q <= 3'h0;
            fast_sign_q <= 1'b0;
        end else begin
            range_q <= range_d;
            tick_cnt_q <= tick_cnt_d;
            pend_q <= pend_d;
            prev_ok_q <= prev_ok_d;
            prev_q <= prev_d;
            sl_up_q <= sl_up_d;
            sl_dn_q <= sl_dn_d;
            ft_above_q <= ft_above_d;
            ft_cnt_q <= ft_cnt_d;
            slope_q <= slope_d;
            slope_axis_q <= slope_axis_d;
            slope_sign_q <= slope_sign_d;
            fast_q <= fast_d;
            fast_axis_q <= fast_axis_d;
            fast_sign_q <= fast_sign_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign slope_event = slope_q;
    assign fast_turn_event = fast_q;

    sequence s_new_point;
        rate_valid && pend_q;
    endsequence
    sequence s_apb_wait;
        psel && penable && !pready_q ##1 pready_q;
    endsequence

    a_slope_set_cause: assert property (@(posedge sys_clk) disable iff (rst) // RULE20
        $rose(slope_q) |-> $past(rate_valid && pend_q))
        else $error("slope event set without a new slope point");
    a_slope_axis_onehot: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
        slope_q |-> $onehot(slope_axis_q))
        else $error("slope axis flags not one-hot");
    a_slope_needs_n: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
        $rose(slope_q) |-> ((slope_axis_q & slope_en) != 3'h0) &&
        ((slope_axis_q[0] && sl_up_q[0] >= n_samp) || (slope_axis_q[1] && sl_up_q[1] >= n_samp)
        || (slope_axis_q[2] && sl_up_q[2] >= n_samp)))
        else $error("slope event set before N points above threshold");
    a_slope_latch_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
        (slope_q && latched && !clr_wr && slope_en != 3'h0) |=> slope_q)
        else $error("latched slope event cleared without reset write");
    a_slope_disable: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
        (slope_en == 3'h0) |=> !slope_q)
        else $error("slope event active with all axes disabled");
    a_fast_axis_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE17
        !fast_q |-> (fast_axis_q == 3'h0))
        else $error("fast turn axis flags left after clear");
    a_fast_set_cause: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
        $rose(fast_q) |-> $past(rate_valid && (ft_qual != 3'h0)))
        else $error("fast turn event set without qualified axis");
    a_fast_quiet: assert property (@(posedge sys_clk) disable iff (rst) // RULE20
        (!rate_valid && !clr_wr && fast_en != 3'h0) |=> $stable(fast_q))
        else $error("fast turn status changed without new data");
    a_apb_answer: assert property (@(posedge sys_clk) disable iff (rst)
        (psel && penable && !pready_q) |-> s_apb_wait ##1 !pready_q)
        else $error("apb answer not exactly one cycle after access");
    a_slope_point_only: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
        s_new_point |=> !pend_q || (tick_cnt_q == 32'h0))
        else $error("slope point pending flag not consumed");
    a_slope_clear_cause: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
        $fell(slope_q) |-> $past((slope_en == 3'h0) || (latched && clr_wr) ||
        (!latched && rate_valid && pend_q)))
        else $error("slope event cleared without a clearing condition");
    a_slope_quiet: assert property (@(posedge sys_clk) disable iff (rst) // RULE20
        (!(rate_valid && pend_q) && !clr_wr && slope_en != 3'h0) |=> $stable(slope_q))
        else $error("slope status changed without a new slope point");
    a_slope_sign_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
        $changed(slope_sign_q) |-> slope_q && $past(rate_valid && pend_q))
        else $error("slope sign changed without a retrigger");
    a_fast_axis_onehot: assert property (@(posedge sys_clk) disable iff (rst) // RULE17
        fast_q |-> $onehot(fast_axis_q))
        else $error("fast turn axis flags not one-hot");
    a_fast_disable: assert property (@(posedge sys_clk) disable iff (rst) // RULE20
        (fast_en == 3'h0) |=> !fast_q)
        else $error("fast turn event active with all axes disabled");
    a_fast_latch_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE19
        (fast_q && latched && !clr_wr && fast_en != 3'h0) |=> fast_q)
        else $error("latched fast turn event cleared without reset write");
    a_fast_clear_cause: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
        $fell(fast_q) |-> $past((fast_en == 3'h0) || (latched && clr_wr) ||
        (!latched && rate_valid && ((ft_lo | ~fast_en) == 3'h7))))
        else $error("fast turn event cleared while an axis stayed high");
endmodule

// ==== tb_gyro_slope_and_rate_alarm.sv ====
`timescale 1ns/10ps
module tb_gyro_slope_and_rate_alarm;
    import gyro_alarm_pkg::*;

`define CHK(nm, ex, got) begin \
    n_compared++; \
    if ((got) !== (ex)) begin \
        failures++; \
        $display("FAIL %s expected %h seen %h", nm, ex, got); \
    end \
end

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rate_valid = 1'b0;
    rate_sample_t rate_in = '0;
    logic [2:0] range_sel = 3'h0;
    logic [2:0] bw_sel = 3'h0;
    logic slope_event;
    logic fast_turn_event;
    int failures = 0;
    int n_compared = 0;
    localparam logic [7:0] RW_IDX [9] = '{IDX_SLOPE_TH, IDX_SLOPE_CFG, IDX_INT_MODE,
        IDX_FAST_CFG[0], IDX_FAST_DUR[0], IDX_FAST_CFG[1], IDX_FAST_DUR[1],
        IDX_FAST_CFG[2], IDX_FAST_DUR[2]};

    // short tick and step keep the run small; counts scale from these
    gyro_slope_and_rate_alarm #(.SLOPE_TICK(8), .HIGH_STEP(4)) dut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rate_valid(rate_valid), .rate_in(rate_in),
        .range_sel(range_sel), .bw_sel(bw_sel), .slope_event(slope_event),
        .fast_turn_event(fast_turn_event));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // one apb transfer; for a read d is the expected register value
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic exp_err);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHK("pready", 1'b1, pready)
        if (!w)
            `CHK("prdata", {24'h000000, d}, prdata)
        `CHK("pslverr", exp_err, pslverr)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic smp(input logic [15:0] x, input logic [15:0] y, input int gap);
        @(posedge sys_clk);
        rate_valid <= 1'b1;
        rate_in.axis[0] <= x;
        rate_in.axis[1] <= y;
        rate_in.axis[2] <= 16'h0000;
        @(posedge sys_clk);
        rate_valid <= 1'b0;
        repeat (gap - 1) @(posedge sys_clk);
        #1;
    endtask

    // bounded wait for an event output to reach a level
    task automatic wait_for(input logic fast, input logic val);
        for (int n = 0; n < 50; n++) begin
            if ((fast ? fast_turn_event : slope_event) === val)
                break;
            @(posedge sys_clk);
            #1;
        end
    endtask

    task automatic done(input string t);
        $display("test %s finished, failures so far %0d", t, failures);
    endtask

    task automatic print_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("FAIL watchdog expected finish seen timeout");
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (RW_IDX[i]) acc(1'b0, RW_IDX[i], 8'h00, 1'b0);
        acc(1'b0, IDX_STATUS, 8'h00, 1'b0);
        acc(1'b1, IDX_SLOPE_TH, 8'hA5, 1'b0);
        acc(1'b0, IDX_SLOPE_TH, 8'hA5, 1'b0);
        acc(1'b1, IDX_FAST_DUR[2], 8'h5A, 1'b0);
        acc(1'b0, IDX_FAST_DUR[2], 8'h5A, 1'b0);
        acc(1'b1, 8'h30, 8'h55, 1'b1);
        acc(1'b0, 8'h30, 8'h00, 1'b1);
        acc(1'b1, IDX_STATUS, 8'hFF, 1'b1);
        acc(1'b0, IDX_STATUS, 8'h00, 1'b0);
        done("registers");

        // threshold 10 steps is 163 raw counts; slopes of 1000 are well above
        acc(1'b1, IDX_SLOPE_TH, 8'h0A, 1'b0);
        acc(1'b1, IDX_SLOPE_CFG, 8'h01, 1'b0);
        smp(16'h0000, 16'h0000, 15);
        for (int i = 0; i < 4; i++) begin
            `CHK("slope_event", 1'b0, slope_event)
            smp(16'(1000 * (i + 1)), 16'h0000, 15);
        end
        `CHK("slope_event", 1'b1, slope_event)
        acc(1'b0, IDX_STATUS, 8'h04, 1'b0);
        acc(1'b0, IDX_SLOPE_INFO, 8'h09, 1'b0);
        for (int i = 0; i < 4; i++) begin
            `CHK("slope_event", 1'b1, slope_event)
            smp(16'd4000, 16'h0000, 15);
        end
        `CHK("slope_event", 1'b0, slope_event)
        acc(1'b0, IDX_SLOPE_INFO, 8'h09, 1'b0);
        done("slope set and clear");

        // longest count, y axis only, falling ramp, latched mode
        acc(1'b1, IDX_INT_MODE, 8'h0F, 1'b0);
        acc(1'b1, IDX_SLOPE_CFG, 8'h32, 1'b0);
        for (int i = 0; i < 16; i++) begin
            `CHK("slope_event", 1'b0, slope_event)
            smp(16'd4000, 16'(-1000 * (i + 1)), 15);
        end
        `CHK("slope_event", 1'b1, slope_event)
        acc(1'b0, IDX_SLOPE_INFO, 8'h02, 1'b0);
        for (int i = 0; i < 17; i++) smp(16'd4000, 16'(-16000), 15);
        `CHK("slope_event", 1'b1, slope_event)
        acc(1'b1, IDX_INT_MODE, 8'h8F, 1'b0);
        wait_for(1'b0, 1'b0);
        `CHK("slope_event", 1'b0, slope_event)
        acc(1'b0, IDX_INT_MODE, 8'h0F, 1'b0);
        acc(1'b1, IDX_INT_MODE, 8'h00, 1'b0);
        acc(1'b1, IDX_SLOPE_CFG, 8'h00, 1'b0);
        done("slope latched");

        // y: threshold 1 step, hysteresis 0, duration 1 gives 8 cycles
        acc(1'b1, IDX_FAST_DUR[1], 8'h01, 1'b0);
        acc(1'b1, IDX_FAST_CFG[1], 8'h03, 1'b0);
        for (int i = 0; i < 4; i++) smp(16'h0000, 16'(-3000), 1);
        `CHK("fast_turn_event", 1'b0, fast_turn_event)
        for (int i = 0; i < 2; i++) smp(16'h0000, 16'(-3000), 1);
        `CHK("fast_turn_event", 1'b1, fast_turn_event)
        acc(1'b0, IDX_STATUS, 8'h02, 1'b0);
        acc(1'b0, IDX_FAST_INFO, 8'h02, 1'b0);
        for (int i = 0; i < 3; i++) smp(16'h0000, 16'(-1500), 1);
        `CHK("fast_turn_event", 1'b1, fast_turn_event)
        smp(16'h0000, 16'd500, 1);
        wait_for(1'b1, 1'b0);
        `CHK("fast_turn_event", 1'b0, fast_turn_event)
        acc(1'b0, IDX_FAST_INFO, 8'h00, 1'b0);
        for (int i = 0; i < 6; i++) smp(16'h0000, 16'd3000, 1);
        `CHK("fast_turn_event", 1'b1, fast_turn_event)
        acc(1'b0, IDX_FAST_INFO, 8'h0A, 1'b0);
        acc(1'b1, IDX_FAST_CFG[1], 8'h43, 1'b0);
        smp(16'h0000, 16'd500, 1);
        `CHK("fast_turn_event", 1'b1, fast_turn_event)
        acc(1'b1, IDX_FAST_CFG[1], 8'h00, 1'b0);
        wait_for(1'b1, 1'b0);
        `CHK("fast_turn_event", 1'b0, fast_turn_event)
        acc(1'b0, IDX_STATUS, 8'h00, 1'b0);
        done("fast turn");

        // code 4 spaces points four times wider, so 40 cycles hold too few
        acc(1'b1, IDX_SLOPE_CFG, 8'h01, 1'b0);
        bw_sel <= 3'h4;
        for (int i = 0; i < 20; i++) smp(16'(500 * (i + 1)), 16'h0000, 1);
        `CHK("slope_event", 1'b0, slope_event)
        @(posedge sys_clk);
        bw_sel <= 3'h0;
        for (int i = 20; i < 40; i++) smp(16'(500 * (i + 1)), 16'h0000, 1);
        `CHK("slope_event", 1'b1, slope_event)
        done("slope spacing");

        // a range switch drops the history, so N fresh points are needed
        acc(1'b1, IDX_SLOPE_CFG, 8'h00, 1'b0);
        acc(1'b1, IDX_SLOPE_CFG, 8'h01, 1'b0);
        for (int i = 0; i < 3; i++) smp(16'(19000 - 1000 * i), 16'h0000, 15);
        `CHK("slope_event", 1'b0, slope_event)
        @(posedge sys_clk);
        range_sel <= 3'h1;
        for (int i = 3; i < 6; i++) smp(16'(19000 - 1000 * i), 16'h0000, 15);
        `CHK("slope_event", 1'b0, slope_event)
        smp(16'd13000, 16'h0000, 15);
        `CHK("slope_event", 1'b1, slope_event)
        acc(1'b0, IDX_SLOPE_INFO, 8'h01, 1'b0);
        done("range switch");

        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        `CHK("slope_event", 1'b0, slope_event)
        acc(1'b0, IDX_SLOPE_CFG, 8'h00, 1'b0);
        acc(1'b0, IDX_SLOPE_TH, 8'h00, 1'b0);
        acc(1'b0, IDX_STATUS, 8'h00, 1'b0);
        done("mid-run reset");
        print_verdict();
    end
endmodule
